//--- inc/flash_self_program_regs.svh
// Register offsets, field positions, reset values and fixed codes
// for the flash self programming control block.
// Assumes a byte-wide special register bus with 16-bit addresses.
`ifndef FLASH_SELF_PROGRAM_REGS_SVH
`define FLASH_SELF_PROGRAM_REGS_SVH

`define ADDR_PROTECT_KEY     16'hffa0
`define ADDR_FLASH_STATUS    16'hffa1
`define ADDR_MODE_CONTROL    16'hffa2
`define ADDR_PROGRAM_COMMAND 16'hffa3
`define ADDR_POINTER_HIGH    16'hffa4
`define ADDR_POINTER_LOW     16'hffa5
`define ADDR_COMPARE_HIGH    16'hffa6
`define ADDR_COMPARE_LOW     16'hffa7
`define ADDR_WRITE_BUFFER    16'hffa8

`define PROTECT_KEY_VALUE    8'ha5
`define ERASED_BYTE          8'hff
`define LAST_LOW_ADDRESS     8'hff
`define PROTECT_NONE         5'h1f

`define STAT_SEQ_ERR_BIT     0
`define STAT_VERIFY_ERR_BIT  1
`define STAT_PROTECT_ERR_BIT 2
`define MODE_SPM_BIT         0
`define MODE_PROT_LSB        2

`define RST_STATUS           3'h0
`define RST_COMMAND          3'h0
`define RST_BYTE             8'h00
`define RST_PROTECT          5'h00

`endif

//--- inc/flash_self_program_pkg.sv
// Types shared by the flash self programming control block.
// Assumes the register header is included where offsets are needed.
package flash_self_program_pkg;

  typedef enum logic [2:0] {
    CMD_NONE         = 3'h0,
    CMD_VERIFY_BLOCK = 3'h1,
    CMD_VERIFY_MULTI = 3'h2,
    CMD_ERASE        = 3'h3,
    CMD_BLANK_CHECK  = 3'h4,
    CMD_BYTE_WRITE   = 3'h5,
    CMD_BAD_6        = 3'h6,
    CMD_BAD_7        = 3'h7
  } command_t;

  typedef enum logic [3:0] {
    SQ_IDLE   = 4'b0001,
    SQ_KEYED  = 4'b0010,
    SQ_FIRST  = 4'b0100,
    SQ_SECOND = 4'b1000
  } seq_state_t;

  typedef enum logic [3:0] {
    EX_IDLE = 4'b0001,
    EX_READ = 4'b0010,
    EX_EVAL = 4'b0100,
    EX_DONE = 4'b1000
  } exec_state_t;

endpackage

//--- src/flash_block_store.sv
// Byte-wide flash array model used by the sequencer.
// Assumes one clock; read data is registered and valid the cycle after rd_en.
`timescale 1ns/1ps
module flash_block_store #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_r <= mem[addr];
    end
  end

endmodule

//--- src/flash_self_program_control.sv
// Flash self programming control: keyed mode change, status flags,
// command sequencer, address pointers, compares, write buffer, protection.
// Assumes the CPU stores and loads one byte per strobe on mclk, and
// pulses exec_start when it halts to run a self programming command.
//
// Contract
// R1 - Bad key write raises sequence error
// R2 - Stray store inside sequence raises sequence error
// R3 - Second write must invert the first
// R4 - Third mismatch errors, mode stays unchanged
// R5 - Sequence error clears by zero or reset
// R6 - Verify failures raise verify error
// R7 - Verify error clears by zero or reset
// R8 - Protected block or zero-to-one raises protect error
// R9 - Protect error clears by zero or reset
// R10 - Codes 1,2 verify block or range
// R11 - Codes 3,4,5 erase, blank check, write
// R12 - Codes 0,6,7 end, set both errors
// R13 - Command register readable, upper bits zero
// R14 - Pointers count up to compare registers; erase ignores them and runs to low address FF
// R15 - Software keeps upper pointer bits zero
// R16 - Software loads compares with block, last
// R17 - Software sets low compare 00/FF
// R18 - Compares, buffer reset zero; pointers not
// R19 - Write buffer supplies byte write data
// R20 - Protection applies only in self programming
// R21 - Sixteen-block protect decoding
// R22 - Thirty-two-block protect decoding
// R23 - Software writes key then value, inverse, value
// R24 - Status flags in bits 0..2
// R25 - Protect byte copied after reset release
// R26 - Refused command leaves flash untouched
`timescale 1ns/1ps
`include "flash_self_program_regs.svh"
module flash_self_program_control #(
  parameter int BLOCKS = 32
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata_r,
  input  wire logic [4:0]  protect_byte_in,
  input  wire logic        exec_start,
  input  wire logic        cell_margin_fail,
  output logic             busy_r,
  output logic             done_r,
  output logic             self_program_mode_select
);
  import flash_self_program_pkg::*;

  localparam int BW = $clog2(BLOCKS);
  localparam int AW = BW + 8;

  if (BLOCKS != 16 && BLOCKS != 32) begin : g_bad_blocks
    $error("BLOCKS must be 16 or 32");
  end

  seq_state_t  seq_r, seq_nxt;
  exec_state_t ex_r, ex_nxt;
  logic [7:0]  first_r, first_nxt;
  logic        spm_r, spm_nxt;
  logic [4:0]  prot_r, prot_nxt;
  logic        prot_loaded_r, prot_loaded_nxt;
  logic [2:0]  status_r, status_nxt;
  logic [2:0]  cmd_r, cmd_nxt;
  logic [7:0]  ph_r, ph_nxt;
  logic [7:0]  pl_r, pl_nxt;
  logic [7:0]  ch_r, ch_nxt;
  logic [7:0]  cl_r, cl_nxt;
  logic [7:0]  wbuf_r, wbuf_nxt;
  logic [7:0]  rdata_nxt;
  logic        busy_nxt;
  logic        done_nxt;
  logic        seq_err;
  logic        ev_verr;
  logic        ev_perr;
  logic        ptr_inc;
  logic        last_addr;
  logic        mem_re;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        wr_key;
  logic        wr_mc;
  logic        wr_status;
  logic        bad_code;

  assign wr_key    = sfr_wr && (sfr_addr == `ADDR_PROTECT_KEY);
  assign wr_mc     = sfr_wr && (sfr_addr == `ADDR_MODE_CONTROL);
  assign wr_status = sfr_wr && (sfr_addr == `ADDR_FLASH_STATUS);
  assign bad_code  = (cmd_r == CMD_NONE) || (cmd_r == CMD_BAD_6) || (cmd_r == CMD_BAD_7);
  assign self_program_mode_select = spm_r;

  // Protected when the block lies at or below the decoded top block
  function automatic logic blk_protected(input logic [4:0] s, input logic [4:0] blk);
    logic [5:0] top;
    top = 6'h00;
    if (s == `PROTECT_NONE) begin
      return 1'b0;
    end
    if (BLOCKS == 16) begin
      // Prohibited codes shield everything
      if (s[4:3] != 2'b01) begin
        return 1'b1;
      end
      top = 6'd15 - {2'b00, s[2:0], 1'b0}; // [R21]
    end else begin
      if (s[4]) begin
        return 1'b1;
      end
      top = 6'd31 - {1'b0, s[3:0], 1'b0}; // [R22]
    end
    return {1'b0, blk} <= top;
  endfunction

  // Keyed mode change, protect byte capture and status flags
  always_comb begin
    seq_nxt         = seq_r;
    first_nxt       = first_r;
    spm_nxt         = spm_r;
    seq_err         = 1'b0;
    prot_nxt        = prot_r;
    prot_loaded_nxt = 1'b1;
    if (!prot_loaded_r) begin
      prot_nxt = protect_byte_in; // [R25]
    end
    if (sfr_wr) begin
      unique case (seq_r)
        SQ_IDLE: begin
          if (wr_key) begin
            if (sfr_wdata == `PROTECT_KEY_VALUE) begin
              seq_nxt = SQ_KEYED;
            end else begin
              seq_err = 1'b1; // [R1]
            end
          end else if (wr_mc) begin
            seq_err = 1'b1; // [R1]
          end
        end
        SQ_KEYED: begin
          if (wr_mc) begin
            first_nxt = sfr_wdata;
            seq_nxt   = SQ_FIRST;
          end else begin
            seq_err = 1'b1; // [R2]
            seq_nxt = SQ_IDLE;
          end
        end
        SQ_FIRST: begin
          if (wr_mc && (sfr_wdata == ~first_r)) begin
            seq_nxt = SQ_SECOND;
          end else begin
            seq_err = 1'b1; // [R2] [R3]
            seq_nxt = SQ_IDLE;
          end
        end
        SQ_SECOND: begin
          seq_nxt = SQ_IDLE;
          if (wr_mc && (sfr_wdata == first_r)) begin
            spm_nxt = sfr_wdata[`MODE_SPM_BIT];
          end else begin
            seq_err = 1'b1; // [R2] [R4]
          end
        end
      endcase
    end
    // Software clears by writing zero; a new event in the same cycle wins
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & sfr_wdata[2:0]; // [R5] [R7] [R9]
    end
    status_nxt[`STAT_SEQ_ERR_BIT]     = status_nxt[`STAT_SEQ_ERR_BIT] | seq_err;
    status_nxt[`STAT_VERIFY_ERR_BIT]  = status_nxt[`STAT_VERIFY_ERR_BIT] | ev_verr; // [R6]
    status_nxt[`STAT_PROTECT_ERR_BIT] = status_nxt[`STAT_PROTECT_ERR_BIT] | ev_perr; // [R8]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_r         <= SQ_IDLE;
      first_r       <= `RST_BYTE;
      spm_r         <= 1'b0;
      prot_r        <= `RST_PROTECT;
      prot_loaded_r <= 1'b0;
      status_r      <= `RST_STATUS; // [R24]
    end else begin
      seq_r         <= seq_nxt;
      first_r       <= first_nxt;
      spm_r         <= spm_nxt;
      prot_r        <= prot_nxt;
      prot_loaded_r <= prot_loaded_nxt;
      status_r      <= status_nxt;
    end
  end

  // Command sequencer over the flash array
  always_comb begin
    ex_nxt    = ex_r;
    mem_re    = 1'b0;
    mem_we    = 1'b0;
    mem_wdata = `ERASED_BYTE;
    ptr_inc   = 1'b0;
    ev_verr   = 1'b0;
    ev_perr   = 1'b0;
    done_nxt  = 1'b0;
    last_addr = (cmd_r == CMD_ERASE) ? (pl_r == `LAST_LOW_ADDRESS)
                                     : ((pl_r == cl_r) && (ph_r == ch_r)); // [R14]
    unique case (ex_r)
      EX_IDLE: begin
        if (exec_start && spm_r && prot_loaded_r) begin
          if (bad_code) begin
            ev_verr = 1'b1; // [R12]
            ev_perr = 1'b1; // [R12]
            ex_nxt  = EX_DONE;
          end else if (blk_protected(prot_r, ph_r[4:0])) begin
            ev_perr = 1'b1; // [R8] [R20] [R26]
            ex_nxt  = EX_DONE;
          end else begin
            ex_nxt = EX_READ;
          end
        end
      end
      EX_READ: begin
        mem_re = 1'b1;
        ex_nxt = EX_EVAL;
      end
      EX_EVAL: begin
        ev_verr = cell_margin_fail; // [R6] [R10]
        case (cmd_r)
          CMD_BLANK_CHECK: begin
            if (mem_rdata != `ERASED_BYTE) begin
              ev_verr = 1'b1; // [R11]
            end
          end
          CMD_ERASE: begin
            mem_we = 1'b1; // [R11]
          end
          CMD_BYTE_WRITE: begin
            if ((~mem_rdata & wbuf_r) != 8'h00) begin
              ev_perr = 1'b1; // [R8]
            end else begin
              mem_we    = 1'b1;
              mem_wdata = wbuf_r; // [R11] [R19]
            end
          end
          default: begin
          end
        endcase
        if ((cmd_r == CMD_BYTE_WRITE) || last_addr) begin
          ex_nxt = EX_DONE;
        end else begin
          ptr_inc = 1'b1; // [R14]
          ex_nxt  = EX_READ;
        end
      end
      EX_DONE: begin
        done_nxt = 1'b1;
        ex_nxt   = EX_IDLE;
      end
    endcase
    busy_nxt = (ex_nxt != EX_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ex_r   <= EX_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      ex_r   <= ex_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  flash_block_store #(
    .AW (AW),
    .DW (8)
  ) u_store (
    .mclk    (mclk),
    .rd_en   (mem_re),
    .wr_en   (mem_we),
    .addr    ({ph_r[BW-1:0], pl_r}),
    .wdata   (mem_wdata),
    .rdata_r (mem_rdata)
  );

  // Software registers; bus stores are ignored while a command runs
  always_comb begin
    cmd_nxt  = cmd_r;
    ph_nxt   = ph_r;
    pl_nxt   = pl_r;
    ch_nxt   = ch_r;
    cl_nxt   = cl_r;
    wbuf_nxt = wbuf_r;
    if (ptr_inc) begin
      {ph_nxt, pl_nxt} = {ph_r, pl_r} + 16'h0001; // [R14]
    end else if (sfr_wr && !busy_r) begin
      unique case (sfr_addr)
        `ADDR_PROGRAM_COMMAND: cmd_nxt = sfr_wdata[2:0]; // [R13]
        `ADDR_POINTER_HIGH:    ph_nxt = sfr_wdata;
        `ADDR_POINTER_LOW:     pl_nxt = sfr_wdata;
        `ADDR_COMPARE_HIGH:    ch_nxt = sfr_wdata; // [R18]
        `ADDR_COMPARE_LOW:     cl_nxt = sfr_wdata; // [R18]
        `ADDR_WRITE_BUFFER:    wbuf_nxt = sfr_wdata; // [R19]
        default: begin
        end
      endcase
    end
  end

  // Pointers carry no reset value
  always_ff @(posedge mclk) begin
    ph_r <= ph_nxt;
    pl_r <= pl_nxt;
    if (!rst_n) begin
      cmd_r  <= `RST_COMMAND; // [R13]
      ch_r   <= `RST_BYTE; // [R18]
      cl_r   <= `RST_BYTE;
      wbuf_r <= `RST_BYTE;
    end else begin
      cmd_r  <= cmd_nxt;
      ch_r   <= ch_nxt;
      cl_r   <= cl_nxt;
      wbuf_r <= wbuf_nxt;
    end
  end

  // Read data one cycle after the load strobe, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `ADDR_FLASH_STATUS:    rdata_nxt = {5'h00, status_r}; // [R24]
        `ADDR_MODE_CONTROL:    rdata_nxt = {1'b0, prot_r, 1'b0, spm_r}; // [R25]
        `ADDR_PROGRAM_COMMAND: rdata_nxt = {5'h00, cmd_r}; // [R13]
        `ADDR_POINTER_HIGH:    rdata_nxt = ph_r;
        `ADDR_POINTER_LOW:     rdata_nxt = pl_r;
        `ADDR_COMPARE_HIGH:    rdata_nxt = ch_r;
        `ADDR_COMPARE_LOW:     rdata_nxt = cl_r;
        `ADDR_WRITE_BUFFER:    rdata_nxt = wbuf_r;
        default:               rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sfr_rdata_r <= `RST_BYTE;
    end else begin
      sfr_rdata_r <= rdata_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_key_bad;
    seq_r == SQ_IDLE && wr_key && sfr_wdata != `PROTECT_KEY_VALUE |=> status_r[0];
  endproperty
  a_key_bad: assert property (p_key_bad) else $error("bad key not flagged"); // [R1]

  property p_stray_store;
    seq_r == SQ_KEYED && sfr_wr && !wr_mc |=> status_r[0] && seq_r == SQ_IDLE;
  endproperty
  a_stray_store: assert property (p_stray_store) else $error("stray store not flagged"); // [R2]

  property p_not_inverse;
    seq_r == SQ_FIRST && wr_mc && sfr_wdata != ~first_r |=> status_r[0] && seq_r == SQ_IDLE;
  endproperty
  a_not_inverse: assert property (p_not_inverse) else $error("bad inverse accepted"); // [R3]

  property p_third_bad;
    seq_r == SQ_SECOND && wr_mc && sfr_wdata != first_r |=> status_r[0] && $stable(spm_r);
  endproperty
  a_third_bad: assert property (p_third_bad) else $error("mode changed on mismatch"); // [R4]

  property p_seq_clear;
    seq_r == SQ_IDLE && wr_status && !sfr_wdata[0] |=> !status_r[0];
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequence error not cleared"); // [R5]

  property p_verr_sticky;
    status_r[1] && !(wr_status && !sfr_wdata[1]) |=> status_r[1];
  endproperty
  a_verr_sticky: assert property (p_verr_sticky) else $error("verify error lost"); // [R7]

  property p_bad_code;
    ex_r == EX_IDLE && exec_start && spm_r && prot_loaded_r && bad_code
      |=> status_r[2:1] == 2'b11 ##1 done_r && !busy_r;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not refused"); // [R12]

  property p_refused_quiet;
    ex_r == EX_IDLE && exec_start && spm_r && prot_loaded_r && !bad_code
      && blk_protected(prot_r, ph_r[4:0]) |=> ex_r == EX_DONE && status_r[2] && !mem_we;
  endproperty
  a_refused_quiet: assert property (p_refused_quiet) else $error("protected block touched"); // [R26]

  property p_zero_to_one;
    ex_r == EX_EVAL && cmd_r == CMD_BYTE_WRITE && (~mem_rdata & wbuf_r) != 8'h00
      |-> !mem_we ##1 status_r[2];
  endproperty
  a_zero_to_one: assert property (p_zero_to_one) else $error("zero-to-one write allowed"); // [R8]

  property p_ptr_step;
    ex_r == EX_EVAL && ex_nxt == EX_READ |=> {ph_r, pl_r} == $past({ph_r, pl_r}) + 16'h0001;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step"); // [R14]

  property p_cmd_read;
    sfr_rd && sfr_addr == `ADDR_PROGRAM_COMMAND |=> sfr_rdata_r == {5'h00, $past(cmd_r)};
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command readback wrong"); // [R13]

endmodule

//--- dv/test_flash_self_program_control.sv
// Self-checking bench for the flash self programming control block.
// Assumes the design package and register header are on the include path.
`timescale 1ns/1ps
`include "flash_self_program_regs.svh"
module test_flash_self_program_control;
  import flash_self_program_pkg::*;
  localparam int BLOCKS = 32;
  localparam int TMO    = 20000;
  logic        mclk;
  logic        rst_n;
  logic [15:0] sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata_r;
  logic [4:0]  protect_byte_in;
  logic        exec_start;
  logic        cell_margin_fail;
  logic        busy_r;
  logic        done_r;
  logic        self_program_mode_select;
  int          n_mismatch;
  int          cmp_count;
  int          cyc;
  int          plim_m;
  logic [7:0]  stat_m;
  logic        mode_m;
  logic [4:0]  prot_m;
  logic [7:0]  wbuf_m;
  logic [7:0]  mem_m [int];
  logic [7:0]  rv;
  logic [7:0]  d;
  logic [7:0]  al;

  flash_self_program_control #(.BLOCKS(BLOCKS)) u_flash_self_program_control (
    .mclk                     (mclk),
    .rst_n                    (rst_n),
    .sfr_addr                 (sfr_addr),
    .sfr_wr                   (sfr_wr),
    .sfr_rd                   (sfr_rd),
    .sfr_wdata                (sfr_wdata),
    .sfr_rdata_r              (sfr_rdata_r),
    .protect_byte_in          (protect_byte_in),
    .exec_start               (exec_start),
    .cell_margin_fail         (cell_margin_fail),
    .busy_r                   (busy_r),
    .done_r                   (done_r),
    .self_program_mode_select (self_program_mode_select)
  );

  always #10 mclk = ~mclk;

  task automatic final_report();
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == TMO) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int s);
    cmp_count++;
    if (s != e) begin
      n_mismatch++;
      $display("FAIL %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge mclk);
    sfr_rd   <= 1'b0;
    #1;
    v = sfr_rdata_r;
  endtask

  task automatic do_reset(input logic [4:0] p);
    protect_byte_in <= p;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    stat_m = 8'h00;
    mode_m = 1'b0;
    wbuf_m = 8'h00;
    prot_m = p;
    if (p == `PROTECT_NONE) plim_m = -1;
    else plim_m = p[4] ? 31 : 31 - 2 * int'(p[3:0]);
  endtask

  task automatic chk_stat();
    rd(`ADDR_FLASH_STATUS, rv);
    chk_byte("status", stat_m, rv);
  endtask

  task automatic wr_stat(input logic [7:0] v);
    wr(`ADDR_FLASH_STATUS, v);
    stat_m = stat_m & v;
  endtask

  task automatic chk_mode();
    rd(`ADDR_MODE_CONTROL, rv);
    chk_byte("mode_control", {1'b0, prot_m, 1'b0, mode_m}, rv);
    chk_byte("mode_pin", {7'h00, mode_m}, {7'h00, self_program_mode_select});
  endtask

  // Key store then three mode-control stores; any slip flags an error
  task automatic seq(input logic [7:0] k, input logic [7:0] v1, input logic [7:0] v2,
                     input logic [7:0] v3);
    wr(`ADDR_PROTECT_KEY, k);
    wr(`ADDR_MODE_CONTROL, v1);
    wr(`ADDR_MODE_CONTROL, v2);
    wr(`ADDR_MODE_CONTROL, v3);
    if (k == `PROTECT_KEY_VALUE && v2 == ~v1 && v3 == v1) mode_m = v1[0];
    else stat_m[0] = 1'b1;
  endtask

  task automatic cmd(input logic [2:0] c, input logic [7:0] ph, input logic [7:0] pl,
                     input logic [7:0] cl, input logic mf);
    int n;
    int lat;
    int a0;
    int a1;
    wr(`ADDR_PROGRAM_COMMAND, {5'h00, c});
    wr(`ADDR_POINTER_HIGH, ph);
    wr(`ADDR_POINTER_LOW, pl);
    wr(`ADDR_COMPARE_HIGH, ph);
    wr(`ADDR_COMPARE_LOW, cl);
    cell_margin_fail <= mf;
    a0 = int'(ph) * 256 + int'(pl);
    a1 = (c == CMD_ERASE) ? int'(ph) * 256 + 255 : int'(ph) * 256 + int'(cl);
    if (c == CMD_BYTE_WRITE) a1 = a0;
    if (c == CMD_NONE || c == CMD_BAD_6 || c == CMD_BAD_7) begin
      lat = 2;
      stat_m[2:1] = 2'b11;
    end else if (int'(ph) <= plim_m) begin
      lat = 2;
      stat_m[2] = 1'b1;
    end else begin
      lat = (c == CMD_BYTE_WRITE) ? 4 : 2 + 2 * (a1 - a0 + 1);
      if (mf) stat_m[1] = 1'b1;
      for (int a = a0; a <= a1; a++) begin
        if (c == CMD_ERASE) mem_m[a] = `ERASED_BYTE;
        if (c == CMD_BLANK_CHECK && mem_m[a] !== `ERASED_BYTE) stat_m[1] = 1'b1;
        if (c == CMD_BYTE_WRITE) begin
          if ((wbuf_m & ~mem_m[a]) != 8'h00) stat_m[2] = 1'b1;
          else mem_m[a] = wbuf_m;
        end
      end
    end
    @(posedge mclk);
    exec_start <= 1'b1;
    @(posedge mclk);
    exec_start <= 1'b0;
    // Take edge is cycle 1; done set at an edge is sampled 1 ns after that same edge
    n = 1;
    while (n < 1200) begin
      @(posedge mclk);
      #1;
      n++;
      if (done_r === 1'b1) break;
    end
    chk_int("latency", lat, n);
    chk_byte("busy_at_done", 8'h00, {7'h00, busy_r});
    cell_margin_fail <= 1'b0;
    chk_stat();
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sfr_addr = 16'h0000;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    protect_byte_in = 5'h00;
    exec_start = 1'b0;
    cell_margin_fail = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'h8aa11423));
    do_reset(5'h0e);
    chk_stat();
    rd(`ADDR_PROGRAM_COMMAND, rv);
    chk_byte("command", 8'h00, rv);
    rd(`ADDR_COMPARE_HIGH, rv);
    chk_byte("compare_high", 8'h00, rv);
    rd(`ADDR_COMPARE_LOW, rv);
    chk_byte("compare_low", 8'h00, rv);
    rd(`ADDR_WRITE_BUFFER, rv);
    chk_byte("write_buffer", 8'h00, rv);
    chk_mode();
    wr(`ADDR_PROGRAM_COMMAND, 8'hff);
    rd(`ADDR_PROGRAM_COMMAND, rv);
    chk_byte("command", 8'h07, rv);
    // Start in normal mode is ignored
    @(posedge mclk);
    exec_start <= 1'b1;
    @(posedge mclk);
    exec_start <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk_byte("busy_normal", 8'h00, {7'h00, busy_r});
    seq(8'h5a, 8'h01, 8'hfe, 8'h01);
    chk_stat();
    chk_mode();
    wr_stat(8'hff);
    chk_stat();
    wr_stat(8'h00);
    chk_stat();
    seq(8'ha5, 8'h01, 8'h01, 8'h01);
    chk_stat();
    wr_stat(8'h00);
    seq(8'ha5, 8'h01, 8'hfe, 8'h00);
    chk_stat();
    chk_mode();
    wr_stat(8'h00);
    wr(`ADDR_PROTECT_KEY, 8'ha5);
    wr(`ADDR_COMPARE_LOW, 8'h00);
    stat_m[0] = 1'b1;
    chk_stat();
    wr_stat(8'h00);
    seq(8'ha5, 8'hff, 8'h00, 8'hff);
    chk_mode();
    chk_stat();
    cmd(CMD_NONE, 8'h04, 8'h00, 8'h00, 1'b0);
    wr_stat(8'h00);
    cmd(CMD_BAD_6, 8'h04, 8'h00, 8'h00, 1'b0);
    wr_stat(8'h00);
    cmd(CMD_BAD_7, 8'h04, 8'h00, 8'h00, 1'b0);
    wr_stat(8'h00);
    cmd(CMD_ERASE, 8'h04, 8'h00, 8'h00, 1'b0);
    cmd(CMD_BLANK_CHECK, 8'h04, 8'h00, 8'hff, 1'b0);
    d = 8'($urandom) & 8'hfe;
    al = 8'($urandom_range(0, 254));
    wr(`ADDR_WRITE_BUFFER, d);
    wbuf_m = d;
    rd(`ADDR_WRITE_BUFFER, rv);
    chk_byte("write_buffer", d, rv);
    cmd(CMD_BYTE_WRITE, 8'h04, al, al, 1'b0);
    wr(`ADDR_WRITE_BUFFER, 8'hff);
    wbuf_m = 8'hff;
    cmd(CMD_BYTE_WRITE, 8'h04, al, al, 1'b0);
    wr_stat(8'hfb);
    chk_stat();
    cmd(CMD_BLANK_CHECK, 8'h04, 8'h00, 8'hff, 1'b0);
    wr_stat(8'hfd);
    chk_stat();
    cmd(CMD_VERIFY_MULTI, 8'h04, 8'h10, 8'h13, 1'b1);
    wr_stat(8'h00);
    cmd(CMD_VERIFY_BLOCK, 8'h05, 8'h00, 8'hff, 1'b1);
    wr_stat(8'h00);
    cmd(CMD_ERASE, 8'h03, 8'h00, 8'h00, 1'b0);
    wr_stat(8'h00);
    // Block 4 becomes shielded; erase must leave it untouched
    do_reset(5'h0d);
    seq(8'ha5, 8'h01, 8'hfe, 8'h01);
    chk_mode();
    cmd(CMD_ERASE, 8'h04, 8'h00, 8'h00, 1'b0);
    do_reset(`PROTECT_NONE);
    seq(8'ha5, 8'h01, 8'hfe, 8'h01);
    cmd(CMD_BLANK_CHECK, 8'h04, 8'h00, 8'hff, 1'b0);
    wr_stat(8'h00);
    cmd(CMD_ERASE, 8'h00, 8'h00, 8'h00, 1'b0);
    final_report();
  end
endmodule
